// ---- shared/hbp_pkg.sv ----
`default_nettype none
package hbp_pkg;
	// ==========================================================
	// widths and clocking
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int CLK_PERIOD_NS = 4;
	localparam int REF_CLK_MHZ = 25;
	localparam int PLL_MULT = 4;
	localparam int SYS_CLK_MHZ = REF_CLK_MHZ * PLL_MULT;
	// ==========================================================
	// timing counts
	// eeprom clock at most 1 MHz: half period least 500 ns
	localparam int EE_HALF_NS = 500;
	localparam int EE_HALF_CYC =
		(EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EE_BITS = 16;
	// activity blink length per event
	localparam int BLINK_NS = 50000000;
	localparam logic [23:0] BLINK_CYC =
		24'(BLINK_NS / CLK_PERIOD_NS);
	// ==========================================================
	// strap encodings {timing, clock source}
	localparam logic [1:0] MODE_SYNC_EXT = 2'h0;
	localparam logic [1:0] MODE_RESERVED = 2'h1;
	localparam logic [1:0] MODE_ASYNC_EXT = 2'h2;
	localparam logic [1:0] MODE_ASYNC_INT = 2'h3;
	// byte order {hi, lo}
	localparam logic [1:0] ORDER_BIG = 2'h0;
	localparam logic [1:0] ORDER_HALF_LE = 2'h1;
	localparam logic [1:0] ORDER_WORD = 2'h2;
	localparam logic [1:0] ORDER_LITTLE = 2'h3;
	// bus width {hi, lo}
	localparam logic [1:0] WIDTH_32 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_8 = 2'h2;
	localparam logic [1:0] WIDTH_RSVD = 2'h3;
	localparam logic [3:0] LANES_32 = 4'hf;
	localparam logic [3:0] LANES_16 = 4'h3;
	localparam logic [3:0] LANES_8 = 4'h1;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic async_bus;
		logic clk_internal;
		logic wait_hi;
		logic [1:0] order;
		logic [1:0] width;
	} hbp_cfg_type;
	localparam hbp_cfg_type CFG_RESET = '0;
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} hbp_req_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARMED = 2'h1,
		ST_BUSY = 2'h2,
		ST_DONE = 2'h3
	} hbp_state_type;
endpackage
`default_nettype wire

// ---- hdl/hbp_host_port.sv ----
// Function
// - internal clock mode selects PLL at four times the 25 MHz reference.
// - external mode uses host bus clock; sync mode samples on it.
// - sync mode captures address at first bus clock rise with select low.
// - async mode captures address once select fall is synchronised.
// - select low starts access; write enable marks write, output enable read.
// - data drivers on only during a read with output enable low.
// - wait asserted while device cannot yet supply or take data.
// - wait active high when polarity strap high, else active low.
// - timing, clock source, polarity straps decode; 0,1,x is reserved.
// - byte order from the two order straps.
// - bus width from two width straps; 11 is reserved.
// - reset floats all outputs that have an enable, aborts work, restores initial values.
// - interrupt open-drain output pulled low on interrupt event.
// - wake output pulled low on wake event.
// - LED driven low to light, floated when off.
// - link LED shows link; activity LED blinks on traffic.
// - eeprom transfer framed by select, clock at most 1 MHz.
// - test logic samples mode select on test clock rise; test reset.
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port #(
	parameter logic [23:0] BLINK_CYCLES = hbp_pkg::BLINK_CYC
) (
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	// host bus pins
	input wire logic i_host_bus_clock,
	input wire logic i_cs_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [9:0] i_addr,
	input wire logic [31:0] i_data_in,
	output logic [31:0] o_data_out,
	output logic [31:0] o_data_oe,
	output logic o_wait,
	output logic o_wait_oe,
	// straps
	input wire logic i_bus_timing_strap,
	input wire logic i_clock_source_strap,
	input wire logic i_wait_polarity_strap,
	input wire logic i_byte_order_strap_lo,
	input wire logic i_byte_order_strap_hi,
	input wire logic i_bus_width_strap_lo,
	input wire logic i_bus_width_strap_hi,
	output hbp_pkg::hbp_cfg_type o_cfg,
	output logic o_cfg_valid,
	output logic o_strap_fault,
	output logic o_clk_sel_pll,
	// internal access side
	output hbp_pkg::hbp_req_type o_req,
	output logic o_req_valid,
	input wire logic i_ack,
	input wire logic [31:0] i_rd_data,
	// events and leds
	input wire logic i_irq_event,
	input wire logic i_wake_event,
	input wire logic i_link_up,
	input wire logic i_activity,
	output logic o_int_n,
	output logic o_int_n_oe,
	output logic o_wake_event_out_n,
	output logic o_wake_event_out_n_oe,
	output logic o_link_led,
	output logic o_link_led_oe,
	output logic o_activity_led,
	output logic o_activity_led_oe,
	// eeprom
	input wire logic i_ee_start,
	input wire logic [15:0] i_ee_wdata,
	input wire logic i_eeprom_data_from_rom,
	output logic o_eeprom_select,
	output logic o_eeprom_serial_clock,
	output logic o_eeprom_data_to_rom,
	output logic o_eeprom_data_to_rom_oe,
	output logic o_ee_busy,
	output logic [15:0] o_ee_rdata,
	// test access
	input wire logic i_test_clock,
	input wire logic i_test_mode_sel,
	input wire logic i_test_data_in,
	input wire logic i_test_reset_n,
	output logic o_test_data_out,
	output logic o_tms_sampled
);
	// ==========================================================
	// pin synchronisers
	logic [3:0] ctl_s1_r, ctl_s2_r;
	logic [41:0] bus_s1_r, bus_s2_r;
	logic [6:0] strap_s1_r, strap_s2_r;
	logic [4:0] misc_s1_r, misc_s2_r;
	logic hbc_d_r, cs_d_r, tck_d_r;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctl_s1_r <= 4'he;
			ctl_s2_r <= 4'he;
			bus_s1_r <= '0;
			bus_s2_r <= '0;
			misc_s1_r <= 5'h01;
			misc_s2_r <= 5'h01;
			hbc_d_r <= 1'b0;
			cs_d_r <= 1'b1;
			tck_d_r <= 1'b0;
		end else if (i_clk_en) begin
			ctl_s1_r <= {i_cs_n, i_we_n, i_oe_n, i_host_bus_clock};
			ctl_s2_r <= ctl_s1_r;
			bus_s1_r <= {i_addr, i_data_in};
			bus_s2_r <= bus_s1_r;
			misc_s1_r <= {i_eeprom_data_from_rom, i_test_clock,
				i_test_mode_sel, i_test_data_in, i_test_reset_n};
			misc_s2_r <= misc_s1_r;
			hbc_d_r <= ctl_s2_r[0];
			cs_d_r <= ctl_s2_r[3];
			tck_d_r <= misc_s2_r[3];
		end
	end
	// straps keep tracking in reset so the capture edge sees settled pins
	always_ff @(posedge i_ref_clk) begin
		if (i_clk_en) begin
			strap_s1_r <= {i_bus_timing_strap, i_clock_source_strap,
				i_wait_polarity_strap, i_byte_order_strap_hi,
				i_byte_order_strap_lo, i_bus_width_strap_hi,
				i_bus_width_strap_lo};
			strap_s2_r <= strap_s1_r;
		end
	end
	logic cs_s, we_s, oe_s, hbc_s;
	logic [9:0] addr_s;
	logic [31:0] data_s;
	assign {cs_s, we_s, oe_s, hbc_s} = ctl_s2_r;
	assign {addr_s, data_s} = bus_s2_r;
	// ==========================================================
	// strap capture, once after reset release
	hbp_pkg::hbp_cfg_type cfg_nxt;
	always_comb begin
		cfg_nxt = '{async_bus: strap_s2_r[6],
			clk_internal: strap_s2_r[5], wait_hi: strap_s2_r[4],
			order: strap_s2_r[3:2], width: strap_s2_r[1:0]};
	end
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cfg <= hbp_pkg::CFG_RESET;
			o_cfg_valid <= 1'b0;
			o_strap_fault <= 1'b0;
			o_clk_sel_pll <= 1'b0;
		end else if (i_clk_en && !o_cfg_valid) begin
			o_cfg <= cfg_nxt;
			o_cfg_valid <= 1'b1;
			o_strap_fault <= ({cfg_nxt.async_bus, cfg_nxt.clk_internal}
				== hbp_pkg::MODE_RESERVED) ||
				(cfg_nxt.width == hbp_pkg::WIDTH_RSVD);
			// internal mode picks the x4 PLL clock
			// otherwise the host bus clock is the system clock
			o_clk_sel_pll <= cfg_nxt.clk_internal;
		end
	end
	// ==========================================================
	// lane helpers
	// byte order swap, an involution so reads and writes share it
	function automatic logic [31:0] order_swap(input logic [31:0] d,
		input logic [1:0] ord, input logic [1:0] wid);
		logic [31:0] r;
		r = d;
		if (wid != hbp_pkg::WIDTH_8) begin
			case (ord)
				hbp_pkg::ORDER_HALF_LE: r = {d[23:16], d[31:24],
					d[7:0], d[15:8]};
				hbp_pkg::ORDER_WORD: r = {d[15:0], d[31:16]};
				hbp_pkg::ORDER_LITTLE: r = {d[7:0], d[15:8],
					d[23:16], d[31:24]};
				default: r = d;
			endcase
		end
		return r;
	endfunction
	// active lanes; reserved width falls back to 32 bits
	function automatic logic [3:0] lanes(input logic [1:0] wid);
		logic [3:0] l;
		case (wid)
			hbp_pkg::WIDTH_16: l = hbp_pkg::LANES_16;
			hbp_pkg::WIDTH_8: l = hbp_pkg::LANES_8;
			default: l = hbp_pkg::LANES_32;
		endcase
		return l;
	endfunction
	logic [3:0] lane_en;
	logic [31:0] lane_bits;
	always_comb begin
		lane_en = lanes(o_cfg.width);
		lane_bits = {{8{lane_en[3]}}, {8{lane_en[2]}}, {8{lane_en[1]}},
			{8{lane_en[0]}}};
	end
	// ==========================================================
	// host bus access sequencer
	hbp_pkg::hbp_state_type state_r;
	logic [9:0] addr_r;
	logic hbc_rise, bus_tick, strobe, start_sync, start_async;
	logic wait_act;
	assign hbc_rise = hbc_s & ~hbc_d_r;
	assign bus_tick = o_cfg.async_bus | hbc_rise;
	assign strobe = ~we_s | ~oe_s;
	assign start_sync = ~o_cfg.async_bus & hbc_rise & ~cs_s;
	assign start_async = o_cfg.async_bus & ~cs_s & cs_d_r;
	// stall while the request is pending
	assign wait_act = (state_r == hbp_pkg::ST_BUSY) ||
		(state_r == hbp_pkg::ST_ARMED && strobe && bus_tick);
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= hbp_pkg::ST_IDLE;
			addr_r <= '0;
			o_req <= '0;
			o_req_valid <= 1'b0;
			o_data_out <= '0;
		end else if (i_clk_en) begin
			o_req_valid <= 1'b0;
			case (state_r)
				hbp_pkg::ST_IDLE: begin
					// sync: first bus clock rise with select low; async: synchronised select fall
					if (o_cfg_valid && (start_sync || start_async)) begin
						addr_r <= addr_s;
						state_r <= hbp_pkg::ST_ARMED;
					end
				end
				hbp_pkg::ST_ARMED: begin
					if (cs_s) begin
						state_r <= hbp_pkg::ST_IDLE;
					end else if (bus_tick && strobe) begin
						// level and data taken on the bus tick
						o_req.write <= ~we_s;
						o_req.addr <= addr_r;
						o_req.data <= order_swap(data_s, o_cfg.order,
							o_cfg.width) & lane_bits;
						o_req_valid <= 1'b1;
						state_r <= hbp_pkg::ST_BUSY;
					end
				end
				hbp_pkg::ST_BUSY: begin
					if (i_ack) begin
						o_data_out <= order_swap(i_rd_data, o_cfg.order,
							o_cfg.width) & lane_bits;
						state_r <= hbp_pkg::ST_DONE;
					end
				end
				hbp_pkg::ST_DONE: begin
					if (cs_s) begin
						state_r <= hbp_pkg::ST_IDLE;
					end
				end
				default: state_r <= hbp_pkg::ST_IDLE;
			endcase
		end
	end
	// wait pin driven only inside a bus cycle
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_wait <= 1'b0;
			o_wait_oe <= 1'b0;
		end else if (i_clk_en) begin
			o_wait <= wait_act ~^ o_cfg.wait_hi;
			o_wait_oe <= o_cfg_valid & ~cs_s;
		end
	end
	// drive only in a read with output enable held low
	for (genvar gi = 0; gi < 32; gi++) begin : g_data_oe
		always_ff @(posedge i_ref_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				o_data_oe[gi] <= 1'b0;
			end else if (i_clk_en) begin
				o_data_oe[gi] <= lane_bits[gi] & ~o_req.write & ~oe_s &
					~cs_s & (state_r == hbp_pkg::ST_DONE);
			end
		end
	end
	// ==========================================================
	// event pins and leds
	logic [23:0] blink_r;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_int_n <= 1'b1;
			o_int_n_oe <= 1'b0;
			o_wake_event_out_n <= 1'b1;
			o_wake_event_out_n_oe <= 1'b0;
			o_link_led <= 1'b1;
			o_link_led_oe <= 1'b0;
			o_activity_led <= 1'b1;
			o_activity_led_oe <= 1'b0;
			blink_r <= '0;
		end else if (i_clk_en) begin
			o_int_n <= ~i_irq_event;
			o_int_n_oe <= i_irq_event;
			o_wake_event_out_n <= ~i_wake_event;
			o_wake_event_out_n_oe <= i_wake_event;
			o_link_led <= ~i_link_up;
			o_link_led_oe <= i_link_up;
			// activity ignored while a blink counts down, lit in first half
			if (i_activity && blink_r == '0) begin
				blink_r <= BLINK_CYCLES;
			end else if (blink_r != '0) begin
				blink_r <= blink_r - 24'h000001;
			end
			o_activity_led <= ~(blink_r > (BLINK_CYCLES >> 1));
			o_activity_led_oe <= blink_r > (BLINK_CYCLES >> 1);
		end
	end
	// ==========================================================
	// eeprom serial engine, msb first, 16 bits
	logic [6:0] ee_div_r;
	logic [4:0] ee_bit_r;
	logic [15:0] ee_sh_r;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ee_div_r <= '0;
			ee_bit_r <= '0;
			ee_sh_r <= '0;
			o_ee_busy <= 1'b0;
			o_ee_rdata <= '0;
			o_eeprom_select <= 1'b0;
			o_eeprom_serial_clock <= 1'b0;
			o_eeprom_data_to_rom <= 1'b0;
			o_eeprom_data_to_rom_oe <= 1'b0;
		end else if (i_clk_en) begin
			if (!o_ee_busy) begin
				if (i_ee_start) begin
					o_ee_busy <= 1'b1;
					o_eeprom_select <= 1'b1;
					o_eeprom_data_to_rom_oe <= 1'b1;
					o_eeprom_data_to_rom <= i_ee_wdata[15];
					ee_sh_r <= i_ee_wdata;
					ee_div_r <= '0;
					ee_bit_r <= '0;
				end
			end else if (ee_div_r == 7'(hbp_pkg::EE_HALF_CYC - 1)) begin
				// half period keeps the clock at 1 MHz or less
				ee_div_r <= '0;
				o_eeprom_serial_clock <= ~o_eeprom_serial_clock;
				if (!o_eeprom_serial_clock) begin
					ee_sh_r <= {ee_sh_r[14:0], misc_s2_r[4]};
				end else if (ee_bit_r == 5'(hbp_pkg::EE_BITS - 1)) begin
					o_ee_busy <= 1'b0;
					o_eeprom_select <= 1'b0;
					o_eeprom_data_to_rom_oe <= 1'b0;
					o_ee_rdata <= ee_sh_r;
				end else begin
					ee_bit_r <= ee_bit_r + 5'h01;
					o_eeprom_data_to_rom <= ee_sh_r[15];
				end
			end else begin
				ee_div_r <= ee_div_r + 7'h01;
			end
		end
	end
	// ==========================================================
	// test access: bypass stage only
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tms_sampled <= 1'b1;
			o_test_data_out <= 1'b0;
		end else if (i_clk_en) begin
			if (!misc_s2_r[0]) begin
				o_tms_sampled <= 1'b1;
				o_test_data_out <= 1'b0;
			end else if (misc_s2_r[3] && !tck_d_r) begin
				o_tms_sampled <= misc_s2_r[2];
				o_test_data_out <= misc_s2_r[1];
			end
		end
	end
	// ==========================================================
	// checks
	a_sync_addr: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) i_clk_en && state_r == hbp_pkg::ST_IDLE
		&& o_cfg_valid && start_sync |=> addr_r == $past(addr_s))
		else $error("sync address not captured");
	a_async_addr: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) i_clk_en && state_r == hbp_pkg::ST_IDLE
		&& o_cfg_valid && start_async |=> state_r == hbp_pkg::ST_ARMED)
		else $error("async select fall missed");
	a_read_drive: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) $past(i_clk_en) && o_data_oe != '0 |->
		$past(state_r) == hbp_pkg::ST_DONE && !o_req.write &&
		$past(oe_s) == 1'b0)
		else $error("data driven outside read");
	a_wait_level: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) i_clk_en && state_r == hbp_pkg::ST_BUSY
		##1 $past(i_clk_en) |-> o_wait == o_cfg.wait_hi)
		else $error("wait polarity wrong");
	a_int_pull: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) i_clk_en && i_irq_event |=>
		o_int_n_oe && !o_int_n)
		else $error("interrupt not pulled low");
	a_wake_pull: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) i_clk_en && i_wake_event |=>
		o_wake_event_out_n_oe && !o_wake_event_out_n)
		else $error("wake not pulled low");
	a_link_led: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) i_clk_en |=>
		o_link_led_oe == $past(i_link_up) && !(o_link_led_oe && o_link_led))
		else $error("link led wrong");
	a_ee_rate: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) $past(i_clk_en) &&
		$changed(o_eeprom_serial_clock) |->
		$past(ee_div_r) == hbp_pkg::EE_HALF_CYC - 1)
		else $error("eeprom clock too fast");
	a_tms_sample: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) i_clk_en && misc_s2_r[0] &&
		misc_s2_r[3] && !tck_d_r |=> o_tms_sampled == $past(misc_s2_r[2]))
		else $error("tms not sampled");
	a_write_take: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn) o_req_valid |->
		o_req.write == !$past(we_s) && state_r == hbp_pkg::ST_BUSY)
		else $error("write level not taken");
endmodule
`default_nettype wire

// ---- tb/hbp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// host processor on the pseudo-sram bus
module hbp_host_model (
	// clock
	input wire logic i_clk,
	// device side
	input wire logic i_wait,
	input wire logic i_wait_hi,
	input wire logic [31:0] i_dev_data,
	input wire logic [31:0] i_dev_oe,
	// host pins
	output logic o_cs_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [9:0] o_addr,
	output logic [31:0] o_data
);
	logic [31:0] drv = 32'h0;
	logic drv_en = 1'b0;
	initial begin
		o_cs_n = 1'b1;
		o_we_n = 1'b1;
		o_oe_n = 1'b1;
		o_addr = 10'h0;
	end
	// released lines show the inverse, not a stale value
	assign o_data = (i_dev_oe & i_dev_data) |
		(~i_dev_oe & (drv_en ? drv : ~drv));
	// ==========
	// one bus cycle; ok means wait was seen and then cleared
	task automatic access(input logic wr, input logic [9:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		logic seen;
		int n;
		seen = 1'b0;
		q = 32'h0;
		@(posedge i_clk);
		// select first, address held till select rises
		o_cs_n <= 1'b0;
		o_addr <= a;
		drv <= d;
		drv_en <= wr;
		@(posedge i_clk);
		if (wr)
			o_we_n <= 1'b0;
		else
			o_oe_n <= 1'b0;
		for (n = 0; n < 60; n++) begin
			@(negedge i_clk);
			if (i_wait === i_wait_hi)
				seen = 1'b1;
			else if (seen)
				break;
		end
		ok = seen && (n < 60);
		q = o_data;
		// strobe kept past wait release for the hold time
		repeat (3) @(posedge i_clk);
		o_we_n <= 1'b1;
		o_oe_n <= 1'b1;
		o_cs_n <= 1'b1;
		drv_en <= 1'b0;
		repeat (4) @(posedge i_clk);
		// callers compare away from the launching edge
		@(negedge i_clk);
	endtask
endmodule
`default_nettype wire

// ---- tb/hbp_host_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_tb;
	// ==========
	// stimulus
	logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_clk_en = 1'b1;
	logic i_host_bus_clock = 1'b0, i_ack = 1'b0;
	logic [31:0] i_rd_data = 32'h0, rd_val = 32'h0;
	logic i_irq_event = 1'b0, i_wake_event = 1'b0, i_link_up = 1'b0;
	logic i_activity = 1'b0, i_ee_start = 1'b0;
	logic i_eeprom_data_from_rom = 1'b1;
	logic [15:0] i_ee_wdata = 16'h0, rom = 16'h5a3c;
	logic i_test_clock = 1'b0, i_test_mode_sel = 1'b1;
	logic i_test_data_in = 1'b0, i_test_reset_n = 1'b1;
	logic [6:0] st = 7'h50;
	logic [1:0] dly = 2'h0;
	// internal clock straps only ever checked at reset, never accessed
	logic [6:0] tbl [5] = '{7'h09, 7'h22, 7'h6f, 7'h4b, 7'h50};
	wire logic i_cs_n, i_we_n, i_oe_n;
	wire logic [9:0] i_addr;
	wire logic [31:0] i_data_in;
	wire logic i_bus_timing_strap = st[6];
	wire logic i_clock_source_strap = st[5];
	wire logic i_wait_polarity_strap = st[4];
	wire logic i_byte_order_strap_hi = st[3];
	wire logic i_byte_order_strap_lo = st[2];
	wire logic i_bus_width_strap_hi = st[1];
	wire logic i_bus_width_strap_lo = st[0];
	// ==========
	// observed
	logic [31:0] o_data_out, o_data_oe;
	logic [15:0] o_ee_rdata;
	logic o_wait, o_wait_oe, o_cfg_valid, o_strap_fault, o_clk_sel_pll;
	logic o_req_valid, o_int_n, o_int_n_oe, o_wake_event_out_n;
	logic o_wake_event_out_n_oe, o_link_led, o_link_led_oe;
	logic o_activity_led, o_activity_led_oe, o_eeprom_select;
	logic o_eeprom_serial_clock, o_eeprom_data_to_rom;
	logic o_eeprom_data_to_rom_oe, o_ee_busy, o_test_data_out;
	logic o_tms_sampled;
	hbp_pkg::hbp_cfg_type o_cfg;
	hbp_pkg::hbp_req_type o_req, req_seen;
	wire logic [5:0] odp = {o_int_n_oe, o_int_n, o_wake_event_out_n_oe,
		o_wake_event_out_n, o_link_led_oe, o_link_led};
	int n_errors = 0, tests_run = 0;

	hbp_host_port #(.BLINK_CYCLES(24'h10)) uut (.i_ref_clk, .i_resetn,
		.i_clk_en, .i_host_bus_clock, .i_cs_n, .i_we_n, .i_oe_n, .i_addr,
		.i_data_in, .o_data_out, .o_data_oe, .o_wait, .o_wait_oe,
		.i_bus_timing_strap, .i_clock_source_strap, .i_wait_polarity_strap,
		.i_byte_order_strap_lo, .i_byte_order_strap_hi,
		.i_bus_width_strap_lo, .i_bus_width_strap_hi, .o_cfg, .o_cfg_valid,
		.o_strap_fault, .o_clk_sel_pll, .o_req, .o_req_valid, .i_ack,
		.i_rd_data, .i_irq_event, .i_wake_event, .i_link_up, .i_activity,
		.o_int_n, .o_int_n_oe, .o_wake_event_out_n, .o_wake_event_out_n_oe,
		.o_link_led, .o_link_led_oe, .o_activity_led, .o_activity_led_oe,
		.i_ee_start, .i_ee_wdata, .i_eeprom_data_from_rom, .o_eeprom_select,
		.o_eeprom_serial_clock, .o_eeprom_data_to_rom,
		.o_eeprom_data_to_rom_oe, .o_ee_busy, .o_ee_rdata, .i_test_clock,
		.i_test_mode_sel, .i_test_data_in, .i_test_reset_n,
		.o_test_data_out, .o_tms_sampled);

	hbp_host_model host (.i_clk(i_ref_clk), .i_wait(o_wait),
		.i_wait_hi(st[4]), .i_dev_data(o_data_out), .i_dev_oe(o_data_oe),
		.o_cs_n(i_cs_n), .o_we_n(i_we_n), .o_oe_n(i_oe_n),
		.o_addr(i_addr), .o_data(i_data_in));

	always #2 i_ref_clk = ~i_ref_clk;
	// free-running host bus clock, 24 ns period
	logic [1:0] hbc_cnt = 2'h0;
	always @(posedge i_ref_clk) begin
		hbc_cnt <= (hbc_cnt == 2'h2) ? 2'h0 : hbc_cnt + 2'h1;
		if (hbc_cnt == 2'h2)
			i_host_bus_clock <= ~i_host_bus_clock;
	end
	// ==========
	// internal side: answers late so wait states show
	always @(posedge i_ref_clk) begin
		i_ack <= 1'b0;
		i_eeprom_data_from_rom <= rom[15];
		if (o_req_valid) begin
			req_seen <= o_req;
			dly <= 2'h3;
		end else if (dly != 2'h0) begin
			dly <= dly - 2'h1;
			i_ack <= (dly == 2'h1);
			i_rd_data <= rd_val;
		end
	end
	// ==========
	// checks and closing
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic do_reset(input logic [6:0] s);
		logic [63:0] e;
		e = 64'({1'b1, s, (s[6:5] == 2'h1) || (s[1:0] == 2'h3), s[5]});
		@(posedge i_ref_clk);
		i_resetn <= 1'b0;
		st <= s;
		repeat (3) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk(64'({o_data_oe, o_wait_oe, odp, o_activity_led_oe}), 64'h2a);
		@(posedge i_ref_clk);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk(64'({o_cfg_valid, o_cfg, o_strap_fault, o_clk_sel_pll}), e);
	endtask
	// ==========
	// main sequence
	initial begin
		logic [31:0] q;
		logic [15:0] cap;
		logic ok, pc;
		int n, last;
		repeat (2) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		foreach (tbl[k])
			do_reset(tbl[k]);
		host.access(1'b1, 10'h2a5, 32'hc3a50f1e, q, ok);
		chk(64'(ok), 64'h1);
		chk(64'(req_seen), 64'({1'b1, 10'h2a5, 32'hc3a50f1e}));
		rd_val = 32'h8d17e24b;
		host.access(1'b0, 10'h3ff, 32'h0, q, ok);
		chk(64'({ok, q}), 64'({1'b1, 32'h8d17e24b}));
		chk(64'({req_seen.write, req_seen.addr}), 64'h3ff);
		chk(64'({o_data_oe, o_wait_oe}), 64'h0);
		// sync bus, external clock, wait active low, little endian
		do_reset(7'h0c);
		host.access(1'b1, 10'h155, 32'h11223344, q, ok);
		chk(64'(ok), 64'h1);
		chk(64'(req_seen), 64'({1'b1, 10'h155, 32'h44332211}));
		@(posedge i_ref_clk);
		{i_irq_event, i_wake_event, i_link_up} <= 3'h7;
		@(posedge i_ref_clk);
		{i_irq_event, i_wake_event, i_link_up} <= 3'h0;
		@(negedge i_ref_clk);
		chk(64'(odp), 64'h2a);
		@(posedge i_ref_clk);
		i_activity <= 1'b1;
		@(negedge i_ref_clk);
		chk(64'(odp), 64'h15);
		@(posedge i_ref_clk);
		i_activity <= 1'b0;
		n = 0;
		repeat (40) begin
			@(negedge i_ref_clk);
			if (o_activity_led_oe === 1'b1 && o_activity_led === 1'b0)
				n++;
		end
		chk(64'(n), 64'd8);
		@(posedge i_ref_clk);
		i_ee_start <= 1'b1;
		i_ee_wdata <= 16'hb3c6;
		@(posedge i_ref_clk);
		i_ee_start <= 1'b0;
		n = 0;
		last = 0;
		pc = 1'b0;
		cap = 16'h0;
		for (int c = 0; c < 6000; c++) begin
			@(negedge i_ref_clk);
			if (o_eeprom_serial_clock && !pc) begin
				cap = {cap[14:0], o_eeprom_data_to_rom};
				chk(64'({o_eeprom_select, o_eeprom_data_to_rom_oe}), 64'h3);
				if (n > 0)
					chk(64'(c - last >= 250), 64'h1);
				last = c;
				n++;
			end
			if (!o_eeprom_serial_clock && pc)
				rom = rom << 1;
			pc = o_eeprom_serial_clock;
			if (o_ee_busy !== 1'b1)
				break;
		end
		chk(64'({n[4:0], cap, o_ee_rdata}), 64'h10_b3c6_5a3c);
		@(posedge i_ref_clk);
		i_test_mode_sel <= 1'b0;
		i_test_data_in <= 1'b1;
		@(posedge i_ref_clk);
		i_test_clock <= 1'b1;
		repeat (6) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk(64'({o_tms_sampled, o_test_data_out}), 64'h1);
		@(posedge i_ref_clk);
		i_test_clock <= 1'b0;
		i_test_reset_n <= 1'b0;
		repeat (6) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk(64'(o_tms_sampled), 64'h1);
		finish_test();
	end
	// ==========
	// watchdog, about five times the expected run
	initial begin
		#80000;
		n_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
